/* rtl/icc_capture_fifo.sv */
/*
  Small capture buffer: first in, first out, depth and width as parameters.
  Ignores a push while full and a pop while empty.
*/
`timescale 1ns/100ps
`default_nettype none

module icc_capture_fifo
  import icc_pkg::*;
#(
  parameter int DW = ICC_DATA_WIDTH,
  parameter int DEPTH = ICC_FIFO_DEPTH,
  parameter int AW = $clog2(DEPTH),
  parameter int LW = $clog2(DEPTH + 1)
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  icc_fifo_if.store fifo
);

  localparam logic [LW-1:0] LEVEL_FULL = LW'(DEPTH);
  localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

  logic [DW-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [LW-1:0] level_r;
  logic do_push;
  logic do_pop;

  assign do_push = fifo.push & (level_r != LEVEL_FULL);
  assign do_pop = fifo.pop & (level_r != '0);

  // storage write
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[wr_ptr_r] <= fifo.wdata;
    end
  end

  // pointers and fill level
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      level_r <= '0;
    end else begin
      if (do_push) begin
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      end
      if (do_pop) begin
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      end
      if (do_push && !do_pop) begin
        level_r <= level_r + 1'b1;
      end else if (do_pop && !do_push) begin
        level_r <= level_r - 1'b1;
      end
    end
  end

  // head word is zero while empty
  assign fifo.rdata = (level_r != '0) ? mem[rd_ptr_r] : '0;
  assign fifo.full = (level_r == LEVEL_FULL);
  assign fifo.not_empty = (level_r != '0);
  assign fifo.level = level_r;

endmodule

`default_nettype wire

/* rtl/icc_edge_detect.sv */
/*
  Edge detector for the capture pin: one-cycle rise and fall strobes.
  Assumes the pin is already synchronous to ref_clk.
*/
`timescale 1ns/100ps
`default_nettype none

module icc_edge_detect
  import icc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic pin,
  output logic rise,
  output logic fall
);

  logic pin_prev_r;

  // previous pin level, reset low
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_prev_r <= 1'b0;
    end else begin
      pin_prev_r <= pin;
    end
  end

  // edge strobes from level change
  assign rise = pin & ~pin_prev_r;
  assign fall = ~pin & pin_prev_r;

endmodule

`default_nettype wire

/* rtl/icc_fifo_if.sv */
/*
  Interface joining the capture channel to its capture buffer.
  Assumes one clock; push and pop are one-cycle strobes.
*/
`timescale 1ns/100ps
`default_nettype none

interface icc_fifo_if #(
  parameter int DW = 16,
  parameter int LW = 3
);
  logic push;
  logic [DW-1:0] wdata;
  logic pop;
  logic [DW-1:0] rdata;
  logic full;
  logic not_empty;
  logic [LW-1:0] level;

  modport owner (output push, output wdata, output pop,
                 input rdata, input full, input not_empty, input level);
  modport store (input push, input wdata, input pop,
                 output rdata, output full, output not_empty, output level);
endinterface

`default_nettype wire

/* rtl/icc_pkg.sv */
/*
  Constants shared by the input capture channel: register offsets, control
  field positions, capture mode codes, interrupt status bits, reset values.
  Assumes a 32-bit APB register bus with byte addresses in the low 12 bits.
*/
package icc_pkg;

  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] ICC_OFS_CONTROL = 12'h000;
  localparam logic [11:0] ICC_OFS_BUFFER = 12'h004;
  localparam logic [11:0] ICC_OFS_IRQ_STATUS = 12'h008;
  localparam logic [11:0] ICC_OFS_IRQ_MASK = 12'h00C;
  localparam logic [11:0] ICC_OFS_STATE = 12'h010;

  // ---------------------------------------------------------------
  // capture_control field positions
  // ---------------------------------------------------------------
  localparam int ICC_CTL_WIDTH = 16;
  localparam int ICC_BIT_HALT_IN_IDLE = 13;
  localparam int ICC_BIT_TIMER_SELECT = 7;
  localparam int ICC_BIT_CPI_HI = 6;
  localparam int ICC_BIT_CPI_LO = 5;
  localparam int ICC_BIT_OVERFLOW = 4;
  localparam int ICC_BIT_NOT_EMPTY = 3;
  localparam int ICC_BIT_MODE_HI = 2;
  localparam int ICC_BIT_MODE_LO = 0;

  // ---------------------------------------------------------------
  // capture_mode codes
  // ---------------------------------------------------------------
  localparam logic [2:0] ICC_MODE_OFF = 3'h0;
  localparam logic [2:0] ICC_MODE_BOTH = 3'h1;
  localparam logic [2:0] ICC_MODE_FALL = 3'h2;
  localparam logic [2:0] ICC_MODE_RISE = 3'h3;
  localparam logic [2:0] ICC_MODE_RISE4 = 3'h4;
  localparam logic [2:0] ICC_MODE_RISE16 = 3'h5;
  localparam logic [2:0] ICC_MODE_UNUSED = 3'h6;
  localparam logic [2:0] ICC_MODE_WAKE = 3'h7;

  // prescaler terminal counts for the divided rising edge modes
  localparam logic [3:0] ICC_PRE_LAST4 = 4'h3;
  localparam logic [3:0] ICC_PRE_LAST16 = 4'hF;

  // ---------------------------------------------------------------
  // interrupt status / mask bits
  // ---------------------------------------------------------------
  localparam int ICC_IRQ_BITS = 3;
  localparam int ICC_IRQ_CAPTURE = 0;
  localparam int ICC_IRQ_OVERFLOW = 1;
  localparam int ICC_IRQ_WAKE = 2;

  // ---------------------------------------------------------------
  // reset values and sizes
  // ---------------------------------------------------------------
  localparam logic [15:0] ICC_CTL_RESET = 16'h0000;
  localparam logic [2:0] ICC_MASK_RESET = 3'h0;
  localparam int ICC_DATA_WIDTH = 16;
  localparam int ICC_FIFO_DEPTH = 4;

endpackage

/* rtl/icc_top.sv */
/*
  Input capture channel top: APB register slave, edge qualification per
  capture mode, prescaler, captures-per-interrupt counter, capture buffer,
  overflow flag, wake interrupt and masked interrupt output.
  Assumes cap_pin, cpu_idle, cpu_sleep and both timer counts are synchronous
  to ref_clk, and an APB master that follows the usual setup/access phases.
*/
// Chosen here: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module icc_top
  import icc_pkg::*;
#(
  parameter int DW = ICC_DATA_WIDTH,
  parameter int DEPTH = ICC_FIFO_DEPTH
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cap_pin,
  input wire logic [DW-1:0] timer_two_count,
  input wire logic [DW-1:0] timer_three_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic irq
);

  localparam int LW = $clog2(DEPTH + 1);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic halt_in_idle_r;
  logic timer_select_r;
  logic [1:0] captures_per_irq_r;
  logic [2:0] capture_mode_r;
  logic capture_overflow_flag_r;
  logic [ICC_IRQ_BITS-1:0] irq_status_r;
  logic [ICC_IRQ_BITS-1:0] irq_status_nxt;
  logic [ICC_IRQ_BITS-1:0] irq_mask_r;
  logic [ICC_IRQ_BITS-1:0] irq_set;
  logic [31:0] prdata_r;
  logic [31:0] rd_mux;
  logic [3:0] pre_cnt_r;
  logic [1:0] irq_cnt_r;
  logic setup_phase;
  logic access_phase;
  logic wr_access;
  logic rd_setup;
  logic addr_hit;
  logic ctl_wr;
  logic status_wr;
  logic mask_wr;
  logic buf_rd;
  logic halted;
  logic rise;
  logic fall;
  logic qual_event;
  logic capture;
  logic capture_irq;
  logic wake_event;
  logic overflow_event;
  logic divided_mode;
  logic counting_off;
  logic [DW-1:0] timer_value;
  logic [ICC_CTL_WIDTH-1:0] control_view;

  icc_fifo_if #(.DW(DW), .LW(LW)) fifo ();

  // ---------------------------------------------------------------
  // submodules
  // ---------------------------------------------------------------

  // rise and fall strobes of the capture pin
  icc_edge_detect u_edge (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .pin(cap_pin),
    .rise(rise),
    .fall(fall)
  );

  // capture buffer
  icc_capture_fifo #(.DW(DW), .DEPTH(DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .fifo(fifo)
  );

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------

  // phase strobes; zero wait state slave
  assign setup_phase = psel & ~penable;
  assign access_phase = psel & penable;
  assign wr_access = access_phase & pwrite;
  assign rd_setup = setup_phase & ~pwrite;
  assign pready = 1'b1;

  // address hit on any mapped word
  assign addr_hit = (paddr == ICC_OFS_CONTROL) || (paddr == ICC_OFS_BUFFER) ||
                    (paddr == ICC_OFS_IRQ_STATUS) || (paddr == ICC_OFS_IRQ_MASK) ||
                    (paddr == ICC_OFS_STATE);
  assign pslverr = access_phase & ~addr_hit;

  // per-register write and read strobes
  assign ctl_wr = wr_access & (paddr == ICC_OFS_CONTROL);
  assign status_wr = wr_access & (paddr == ICC_OFS_IRQ_STATUS);
  assign mask_wr = wr_access & (paddr == ICC_OFS_IRQ_MASK);
  assign buf_rd = rd_setup & (paddr == ICC_OFS_BUFFER); // pop with the data load, no capture lost

  // ---------------------------------------------------------------
  // control register
  // ---------------------------------------------------------------

  // software writable control fields
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      halt_in_idle_r <= ICC_CTL_RESET[ICC_BIT_HALT_IN_IDLE];
      timer_select_r <= ICC_CTL_RESET[ICC_BIT_TIMER_SELECT];
      captures_per_irq_r <= ICC_CTL_RESET[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO];
      capture_mode_r <= ICC_CTL_RESET[ICC_BIT_MODE_HI:ICC_BIT_MODE_LO];
    end else if (ctl_wr) begin
      halt_in_idle_r <= pwdata[ICC_BIT_HALT_IN_IDLE];
      timer_select_r <= pwdata[ICC_BIT_TIMER_SELECT];
      captures_per_irq_r <= pwdata[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO];
      capture_mode_r <= pwdata[ICC_BIT_MODE_HI:ICC_BIT_MODE_LO];
    end
  end

  // read view of the control word, status bits from hardware
  always_comb begin
    control_view = '0;
    control_view[ICC_BIT_HALT_IN_IDLE] = halt_in_idle_r;
    control_view[ICC_BIT_TIMER_SELECT] = timer_select_r;
    control_view[ICC_BIT_CPI_HI:ICC_BIT_CPI_LO] = captures_per_irq_r;
    control_view[ICC_BIT_OVERFLOW] = capture_overflow_flag_r;
    control_view[ICC_BIT_NOT_EMPTY] = fifo.not_empty;
    control_view[ICC_BIT_MODE_HI:ICC_BIT_MODE_LO] = capture_mode_r;
  end

  // ---------------------------------------------------------------
  // edge qualification
  // ---------------------------------------------------------------

  assign halted = halt_in_idle_r & cpu_idle & (capture_mode_r != ICC_MODE_WAKE);

  // modes that run the rising edge prescaler
  assign divided_mode = (capture_mode_r == ICC_MODE_RISE4) || (capture_mode_r == ICC_MODE_RISE16);

  // modes in which counters must stay at zero
  assign counting_off = (capture_mode_r == ICC_MODE_OFF) || (capture_mode_r == ICC_MODE_UNUSED) ||
                        (capture_mode_r == ICC_MODE_WAKE);

  // capture event per mode
  always_comb begin
    qual_event = 1'b0;
    unique case (capture_mode_r)
      ICC_MODE_OFF: qual_event = 1'b0;
      ICC_MODE_BOTH: qual_event = rise | fall;
      ICC_MODE_FALL: qual_event = fall;
      ICC_MODE_RISE: qual_event = rise;
      ICC_MODE_RISE4: qual_event = rise & (pre_cnt_r[1:0] == ICC_PRE_LAST4[1:0]);
      ICC_MODE_RISE16: qual_event = rise & (pre_cnt_r == ICC_PRE_LAST16);
      ICC_MODE_UNUSED: qual_event = 1'b0;
      ICC_MODE_WAKE: qual_event = 1'b0;
    endcase
  end

  assign capture = qual_event & ~halted;

  // rising edge prescaler, restarted by any control write
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pre_cnt_r <= '0;
    end else if (ctl_wr || !divided_mode) begin
      pre_cnt_r <= '0;
    end else if (rise && !halted) begin
      if (capture_mode_r == ICC_MODE_RISE4 && pre_cnt_r[1:0] == ICC_PRE_LAST4[1:0]) begin
        pre_cnt_r <= '0;
      end else begin
        pre_cnt_r <= pre_cnt_r + 4'h1;
      end
    end
  end

  // ---------------------------------------------------------------
  // capture into the buffer
  // ---------------------------------------------------------------

  assign timer_value = timer_select_r ? timer_two_count : timer_three_count;

  assign fifo.push = capture & ~fifo.full;
  assign fifo.wdata = timer_value;
  assign fifo.pop = buf_rd;
  assign overflow_event = capture & fifo.full;

  // sticky overflow, cleared only by turning the channel off
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      capture_overflow_flag_r <= 1'b0;
    end else if (overflow_event) begin
      capture_overflow_flag_r <= 1'b1;
    end else if (capture_mode_r == ICC_MODE_OFF) begin
      capture_overflow_flag_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // captures per interrupt
  // ---------------------------------------------------------------

  // both-edge mode interrupts each capture, other modes on capture captures_per_irq_r + 1
  assign capture_irq = capture & ((capture_mode_r == ICC_MODE_BOTH) || (irq_cnt_r >= captures_per_irq_r));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_cnt_r <= '0;
    end else if (ctl_wr || counting_off) begin
      irq_cnt_r <= '0;
    end else if (capture_irq) begin
      irq_cnt_r <= '0;
    end else if (capture) begin
      irq_cnt_r <= irq_cnt_r + 2'h1;
    end
  end

  // wake on rising edge in sleep or idle
  assign wake_event = (capture_mode_r == ICC_MODE_WAKE) & rise & (cpu_sleep | cpu_idle);

  // ---------------------------------------------------------------
  // interrupt status and mask
  // ---------------------------------------------------------------

  // event set vector
  always_comb begin
    irq_set = '0;
    irq_set[ICC_IRQ_CAPTURE] = capture_irq;
    irq_set[ICC_IRQ_OVERFLOW] = overflow_event;
    irq_set[ICC_IRQ_WAKE] = wake_event;
  end

  // write one to clear, a same-cycle event wins
  always_comb begin
    irq_status_nxt = irq_status_r;
    if (status_wr) begin
      irq_status_nxt = irq_status_nxt & ~pwdata[ICC_IRQ_BITS-1:0];
    end
    irq_status_nxt = irq_status_nxt | irq_set;
  end

  // sticky status
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_status_r <= '0;
    end else begin
      irq_status_r <= irq_status_nxt;
    end
  end

  // interrupt mask
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_mask_r <= ICC_MASK_RESET;
    end else if (mask_wr) begin
      irq_mask_r <= pwdata[ICC_IRQ_BITS-1:0];
    end
  end

  // level interrupt from unmasked status
  assign irq = |(irq_status_r & irq_mask_r);

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------

  // read mux, unmapped words read zero
  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      ICC_OFS_CONTROL: rd_mux = 32'(control_view);
      ICC_OFS_BUFFER: rd_mux = 32'(fifo.rdata);
      ICC_OFS_IRQ_STATUS: rd_mux = 32'(irq_status_r);
      ICC_OFS_IRQ_MASK: rd_mux = 32'(irq_mask_r);
      ICC_OFS_STATE: rd_mux = {16'h0000, 4'(fifo.level), pre_cnt_r, 2'h0, irq_cnt_r, 3'h0, halted};
      default: rd_mux = '0;
    endcase
  end

  // read data latched in the setup phase, held through access
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      prdata_r <= '0;
    end else if (setup_phase && !pwrite) begin
      prdata_r <= rd_mux;
    end
  end

  assign prdata = prdata_r;

endmodule

`default_nettype wire

/* tb/icc_pin_model.sv */
/*
  Behavioural source of the external capture pin.
  Assumes callers enter just after a rising ref_clk edge.
*/
`timescale 1ns/100ps
`default_nettype none

module icc_pin_model (
  input wire logic ref_clk,
  output logic cap_pin
);
  // pin rests low
  initial cap_pin = 1'b0;
  // n level changes, gap cycles apart, fast or slow
  task automatic toggle(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      cap_pin <= ~cap_pin;
      repeat (gap) @(posedge ref_clk);
    end
  endtask
endmodule

`default_nettype wire

/* tb/icc_top_chk.sv */
/*
  Port checker for icc_top, bound to it at the foot of this file.
  Assumes one clock ref_clk and rst_b synchronous active low.
*/
`timescale 1ns/100ps
`default_nettype none

module icc_top_chk
  import icc_pkg::*;
#(
  parameter int DW = ICC_DATA_WIDTH,
  parameter int DEPTH = ICC_FIFO_DEPTH
)(
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic cap_pin,
  input wire logic [DW-1:0] timer_two_count,
  input wire logic [DW-1:0] timer_three_count,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  input wire logic irq
);
  // ------------------------------
  // decode and pin history
  // ------------------------------
  logic acc;
  logic mapped;
  logic pin_q;
  // access phase and mapped word
  assign acc = psel && penable;
  assign mapped = paddr inside {ICC_OFS_CONTROL, ICC_OFS_BUFFER, ICC_OFS_IRQ_STATUS, ICC_OFS_IRQ_MASK, ICC_OFS_STATE};
  // previous pin level, low out of reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= cap_pin;
    end
  end
  // ------------------------------
  // assertions
  // ------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  sequence ctl_wr;
    acc && pwrite && paddr == ICC_OFS_CONTROL;
  endsequence
  sequence ctl_rd;
    psel && !penable && !pwrite && paddr == ICC_OFS_CONTROL;
  endsequence
  chk_ready_high: assert property (pready)
    else $error("pready low");
  chk_err_unmapped: assert property (acc && !mapped |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_mapped: assert property (acc && mapped |-> !pslverr)
    else $error("error on mapped access");
  chk_err_setup: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  chk_ctl_readback: assert property (
    ctl_wr ##2 ctl_rd |=> (prdata[15:0] & 16'h20E7) == ($past(pwdata[15:0], 3) & 16'h20E7))
    else $error("control readback differs");
  chk_irq_rise: assert property (
    $rose(irq) |-> $past(cap_pin != pin_q) || $past(acc && pwrite))
    else $error("irq rose without cause");
  chk_irq_fall: assert property ($fell(irq) |-> $past(acc && pwrite))
    else $error("irq fell without write");
  chk_unmapped_zero: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved outside setup");
endmodule

bind icc_top icc_top_chk #(.DW(DW), .DEPTH(DEPTH)) icc_top_chk_i (
  .ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .cap_pin(cap_pin), .timer_two_count(timer_two_count), .timer_three_count(timer_three_count),
  .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));

`default_nettype wire

/* tb/test_input_capture_channel.sv */
/*
  Self-checking bench for icc_top: APB tasks, pin model, directed tests.
  Assumes a zero-wait slave and the register map of icc_pkg.
*/
`timescale 1ns/100ps
`default_nettype none

module test_input_capture_channel;
  import icc_pkg::*;
  // ------------------------------
  // signals and instances
  // ------------------------------
  localparam logic [11:0] CTL = ICC_OFS_CONTROL;
  localparam logic [11:0] BUF = ICC_OFS_BUFFER;
  localparam logic [11:0] STA = ICC_OFS_IRQ_STATUS;
  localparam logic [11:0] MSK = ICC_OFS_IRQ_MASK;
  logic ref_clk, rst_b, psel, penable, pwrite, pready, pslverr, cap_pin;
  logic cpu_idle, cpu_sleep, irq, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [15:0] t2, t3;
  int errors, num_checks, cyc;
  int lvl [8] = '{0, 4, 4, 4, 4, 1, 0, 0};
  logic ov [8] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  logic [15:0] fifo_exp [4] = '{16'h1001, 16'h1002, 16'h3003, 16'h0000};

  icc_top icc_top_i (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_pin(cap_pin), .timer_two_count(t2), .timer_three_count(t3),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq));
  icc_pin_model icc_pin_model_i (.ref_clk(ref_clk), .cap_pin(cap_pin));

  // clock and cycle ceiling
  always #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      wrap_up();
    end
  end
  // ------------------------------
  // tasks
  // ------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one APB transfer, answer taken at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    // wait for the answer; only the cycle ceiling ends a hang
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, exp, rd_q);
  endtask
  task automatic pin(input int n, input int gap);
    icc_pin_model_i.toggle(n, gap);
  endtask
  // channel off, buffer drained, status cleared
  task automatic clean();
    wr(CTL, 32'h0);
    repeat (4) apb(1'b0, BUF, 32'h0);
    wr(STA, 32'h7);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // ------------------------------
  // tests
  // ------------------------------
  initial begin
    ref_clk = 1'b0;
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    t2 = 16'h0000;
    t3 = 16'h00C3;
    cpu_idle = 1'b0;
    cpu_sleep = 1'b0;
    errors = 0;
    num_checks = 0;
    cyc = 0;
    repeat (4) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    // reset values, access kinds, unmapped word
    rd("ctl reset", CTL, 32'h0);
    rd("mask reset", MSK, 32'h0);
    check("irq reset", 32'h0, {31'h0, irq});
    wr(12'h014, 32'hFFFFFFFF);
    check("wr slverr", 32'h1, {31'h0, err_q});
    rd("unmapped", 12'h014, 32'h0);
    wr(CTL, 32'hFFFE);
    rd("ctl rw", CTL, 32'h20E6);
    check("slverr", 32'h0, {31'h0, err_q});
    $display("test registers done");
    clean();
    // every mode against 16 rises and 16 falls
    for (int m = 0; m < 8; m++) begin
      wr(CTL, 32'(m));
      pin(32, 1);
      @(posedge ref_clk);
      rd("mode ctl", CTL, {27'h0, ov[m], lvl[m] != 0, 3'(m)});
      rd("mode sta", STA, {30'h0, ov[m], lvl[m] != 0});
      apb(1'b0, ICC_OFS_STATE, 32'h0);
      check("level", 32'(lvl[m]), {28'h0, rd_q[15:12]});
      clean();
    end
    $display("test modes done");
    // timer select and buffer order
    wr(CTL, 32'h80 | ICC_MODE_RISE);
    t2 <= 16'h1001;
    t3 <= 16'h5A5A;
    pin(2, 1);
    t2 <= 16'h1002;
    pin(2, 1);
    wr(CTL, 32'(ICC_MODE_RISE));
    t3 <= 16'h3003;
    pin(2, 3);
    for (int k = 0; k < 4; k++) rd("buffer", BUF, {16'h0, fifo_exp[k]});
    rd("empty", CTL, 32'(ICC_MODE_RISE));
    // drop the capture status left by this test before the interrupt test
    clean();
    $display("test buffer done");
    // captures per interrupt, masking and clearing
    wr(MSK, 32'h1);
    for (int c = 0; c < 4; c++) begin
      wr(CTL, 32'(ICC_MODE_RISE) | 32'(c << 5));
      for (int k = 0; k <= c; k++) begin
        pin(2, 3);
        check("cpi irq", 32'(k == c), {31'h0, irq});
      end
      clean();
    end
    wr(CTL, 32'h60 | ICC_MODE_BOTH);
    pin(1, 3);
    check("both irq", 32'h1, {31'h0, irq});
    wr(MSK, 32'h0);
    check("masked", 32'h0, {31'h0, irq});
    wr(MSK, 32'h1);
    check("unmasked", 32'h1, {31'h0, irq});
    wr(STA, 32'h1);
    check("cleared", 32'h0, {31'h0, irq});
    pin(1, 3);
    clean();
    $display("test interrupt done");
    // halt while idle
    wr(CTL, 32'h2000 | ICC_MODE_RISE);
    cpu_idle <= 1'b1;
    pin(2, 1);
    apb(1'b0, ICC_OFS_STATE, 32'h0);
    check("halted", 32'h0, {28'h0, rd_q[15:12]});
    wr(CTL, 32'(ICC_MODE_RISE));
    pin(2, 1);
    apb(1'b0, ICC_OFS_STATE, 32'h0);
    check("running", 32'h1, {28'h0, rd_q[15:12]});
    cpu_idle <= 1'b0;
    clean();
    $display("test halt done");
    // wake pin: rise only, only while asleep or idle
    wr(MSK, 32'h4);
    wr(CTL, 32'h20E7);
    pin(1, 3);
    rd("awake rise", STA, 32'h0);
    cpu_sleep <= 1'b1;
    pin(1, 3);
    rd("sleep fall", STA, 32'h0);
    pin(1, 3);
    rd("sleep rise", STA, 32'h4);
    check("wake irq", 32'h1, {31'h0, irq});
    rd("no capture", CTL, 32'h20E7);
    cpu_sleep <= 1'b0;
    pin(1, 3);
    clean();
    $display("test wake done");
    wrap_up();
  end
endmodule

`default_nettype wire
